// *** core/cisp_pkg.sv ***
// constants and types shared by both ends of the custom instruction slot port
// assumes a single system clock shared by the processor side and the custom logic
package cisp_pkg;

  localparam int DATA_W           = 32;
  localparam int SEL_MAX_W        = 8;
  localparam int NUM_OPS_DEF      = 7;
  localparam int ITER_STEPS       = 32;
  localparam int FIXED_CYCLES_DEF = 34;
  localparam bit VAR_LEN_DEF      = 1'b1;

  localparam logic [SEL_MAX_W-1:0] OP_BITSWAP  = 8'h00;
  localparam logic [SEL_MAX_W-1:0] OP_BYTESWAP = 8'h01;
  localparam logic [SEL_MAX_W-1:0] OP_HALFSWAP = 8'h02;
  localparam logic [SEL_MAX_W-1:0] OP_ADD      = 8'h03;
  localparam logic [SEL_MAX_W-1:0] OP_SUB      = 8'h04;
  localparam logic [SEL_MAX_W-1:0] OP_MUL      = 8'h05;
  localparam logic [SEL_MAX_W-1:0] OP_DIVU     = 8'h06;

  localparam logic [DATA_W-1:0] RESULT_RST = 32'h0000_0000;

  typedef enum logic [1:0] {CISP_DEV_IDLE, CISP_DEV_MUL, CISP_DEV_DIV} cisp_dev_st_t;
  typedef enum logic [1:0] {CISP_CPU_IDLE, CISP_CPU_COMB, CISP_CPU_MULTI} cisp_cpu_st_t;

endpackage

// *** core/cisp_if.sv ***
// signal bundle between the processor issue logic and the custom logic block
// assumes clk is the system clock of both ends
`timescale 1ns/1ps
`default_nettype none
interface cisp_if (
  input wire logic clk
);
  logic                          reset;
  logic                          clk_en;
  logic                          start;
  logic                          done;
  logic [cisp_pkg::DATA_W-1:0]   dataa;
  logic [cisp_pkg::DATA_W-1:0]   datab;
  logic [cisp_pkg::SEL_MAX_W-1:0] n;
  logic [cisp_pkg::DATA_W-1:0]   result;
  logic [cisp_pkg::DATA_W-1:0]   comb_result;

  modport dev (
    input  clk, reset, clk_en, start, dataa, datab, n,
    output done, result, comb_result
  );
  modport cpu (
    input  clk, done, result, comb_result,
    output reset, clk_en, start, dataa, datab, n
  );
endinterface
`default_nettype wire

// *** core/cisp_swap.sv ***
// combinational function unit: swaps and add/sub picked by an operation select
// assumes operands are held stable by the caller for the whole cycle
`timescale 1ns/1ps
`default_nettype none
module cisp_swap #(
  parameter int SEL_W = 3
) (
  input  wire logic [cisp_pkg::DATA_W-1:0] i_a,
  input  wire logic [cisp_pkg::DATA_W-1:0] i_b,
  input  wire logic [SEL_W-1:0]            i_sel,
  output logic      [cisp_pkg::DATA_W-1:0] o_result
);
  function automatic logic [cisp_pkg::DATA_W-1:0] bit_rev(input logic [cisp_pkg::DATA_W-1:0] v);
    logic [cisp_pkg::DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < cisp_pkg::DATA_W; i++) begin
      r[i] = v[cisp_pkg::DATA_W-1-i];
    end
    return r;
  endfunction

  logic [cisp_pkg::SEL_MAX_W-1:0] sel_full;
  assign sel_full = cisp_pkg::SEL_MAX_W'(i_sel);

  // output multiplexer steered by the select field
  always_comb begin
    unique case (sel_full)
      cisp_pkg::OP_BITSWAP:  o_result = bit_rev(i_a);
      cisp_pkg::OP_BYTESWAP: o_result = {i_a[7:0], i_a[15:8], i_a[23:16], i_a[31:24]};
      cisp_pkg::OP_HALFSWAP: o_result = {i_a[15:0], i_a[31:16]};
      cisp_pkg::OP_ADD:      o_result = i_a + i_b;
      cisp_pkg::OP_SUB:      o_result = i_a - i_b;
      default:               o_result = cisp_pkg::RESULT_RST;
    endcase
  end
endmodule // cisp_swap
`default_nettype wire

// *** core/cisp_dev.sv ***
// custom logic block end: combinational swap/add path plus multi-cycle mul/div
// assumes the processor end drives the interface and holds operands during an operation
// Functional notes
// - combinational result within one cycle, no controls
// - result always present; operands only if needed
// - single-operand functions use the first operand
// - operands at one edge, result next edge
// - speculative combinational path has no external interface
// - multi-cycle: fixed count or start/done handshake
// - multi-cycle needs clock, qualifier and reset inputs
// - processor raises start, holds operands until done
// - fixed n cycles: result valid by edge n-1
// - variable: result sampled on the done edge
// - system clock, synchronous active-high system reset
// - qualifier low means clock edge is ignored; op_pulse_r is not gated and clears on an unqualified edge
// - unrecognised ports go to external logic
// - 8-bit select chooses among up to 256 functions
// - select width follows from number of operations
// - select presented with start, held until finished
// - select drives the output result multiplexer
`timescale 1ns/1ps
`default_nettype none
module cisp_dev #(
  parameter bit VAR_LEN = cisp_pkg::VAR_LEN_DEF,
  parameter int NUM_OPS = cisp_pkg::NUM_OPS_DEF
) (
  cisp_if.dev              ci,
  output logic             o_ext_busy,
  output logic             o_ext_op_pulse,
  output logic [15:0]      o_ext_op_count
);
  localparam int SEL_W = (NUM_OPS > 1) ? $clog2(NUM_OPS) : 1;
  localparam int DW    = cisp_pkg::DATA_W;
  localparam logic [5:0] LAST_STEP = 6'(cisp_pkg::ITER_STEPS - 1);

  function automatic logic is_iter(input logic [cisp_pkg::SEL_MAX_W-1:0] op);
    return (op == cisp_pkg::OP_MUL) || (op == cisp_pkg::OP_DIVU);
  endfunction

  // one shift-add multiplier step, shared by the datapath and the result load
  function automatic logic [cisp_pkg::DATA_W-1:0] mul_step(
    input logic [cisp_pkg::DATA_W-1:0] acc,
    input logic [cisp_pkg::DATA_W-1:0] mcand,
    input logic                        add_en
  );
    return add_en ? (acc + mcand) : acc;
  endfunction

  // one restoring-division quotient step; dividend bits leave as quotient bits enter
  function automatic logic [cisp_pkg::DATA_W-1:0] quo_step(
    input logic [cisp_pkg::DATA_W-1:0] quo,
    input logic                        q_bit
  );
    return {quo[cisp_pkg::DATA_W-2:0], q_bit};
  endfunction

  cisp_pkg::cisp_dev_st_t state_r;
  logic [SEL_W-1:0]        sel;
  logic [cisp_pkg::SEL_MAX_W-1:0] op_full;
  logic [DW-1:0]           comb_out;
  logic [5:0]              step_r;
  logic [DW-1:0]           acc_r;
  logic [DW-1:0]           mcand_r;
  logic [DW-1:0]           mplier_r;
  logic [DW:0]             rem_r;
  logic [DW-1:0]           quo_r;
  logic [DW-1:0]           divisor_r;
  logic [DW:0]             rem_shift;
  logic                    rem_ge;
  logic                    finish;
  logic [DW-1:0]           result_r;
  logic                    done_r;
  logic                    op_pulse_r;
  logic [15:0]             op_count_r;
  logic                    busy_r;
  logic                    take;

  // only the low select bits that the operation count needs are decoded
  assign sel     = ci.n[SEL_W-1:0];
  assign op_full = cisp_pkg::SEL_MAX_W'(sel);

  // combinational variant: operands straight to result, no controls,
  // no path to external logic since issue may be speculative
  cisp_swap #(
    .SEL_W    (SEL_W)
  ) u_swap (
    .i_a      (ci.dataa),
    .i_b      (ci.datab),
    .i_sel    (sel),
    .o_result (comb_out)
  );
  assign ci.comb_result = comb_out;

  // start is only seen on a qualified edge
  assign take   = ci.clk_en && ci.start && (state_r == cisp_pkg::CISP_DEV_IDLE);
  assign finish = ci.clk_en && (state_r != cisp_pkg::CISP_DEV_IDLE) && (step_r == LAST_STEP);

  // restoring division step
  assign rem_shift = {rem_r[DW-1:0], quo_r[DW-1]};
  assign rem_ge    = rem_shift >= {1'b0, divisor_r};

  // sequencer for the iterative operations
  always_ff @(posedge ci.clk) begin
    if (ci.reset) begin
      state_r <= cisp_pkg::CISP_DEV_IDLE;
      step_r  <= '0;
    end else if (ci.clk_en) begin
      unique case (state_r)
        cisp_pkg::CISP_DEV_IDLE: begin
          step_r <= '0;
          if (ci.start && is_iter(op_full)) begin
            state_r <= (op_full == cisp_pkg::OP_MUL) ? cisp_pkg::CISP_DEV_MUL
                                                      : cisp_pkg::CISP_DEV_DIV;
          end
        end
        cisp_pkg::CISP_DEV_MUL,
        cisp_pkg::CISP_DEV_DIV: begin
          step_r <= step_r + 6'h01;
          if (step_r == LAST_STEP) begin
            state_r <= cisp_pkg::CISP_DEV_IDLE;
          end
        end
      endcase
    end
  end

  // shift-add multiplier datapath
  always_ff @(posedge ci.clk) begin
    if (ci.reset) begin
      acc_r    <= '0;
      mcand_r  <= '0;
      mplier_r <= '0;
    end else if (ci.clk_en) begin
      if (take) begin
        acc_r    <= '0;
        mcand_r  <= ci.dataa;
        mplier_r <= ci.datab;
      end else if (state_r == cisp_pkg::CISP_DEV_MUL) begin
        acc_r    <= mul_step(acc_r, mcand_r, mplier_r[0]);
        mcand_r  <= {mcand_r[DW-2:0], 1'b0};
        mplier_r <= {1'b0, mplier_r[DW-1:1]};
      end
    end
  end

  // unsigned divider datapath, divide by zero gives all ones
  always_ff @(posedge ci.clk) begin
    if (ci.reset) begin
      rem_r     <= '0;
      quo_r     <= '0;
      divisor_r <= '0;
    end else if (ci.clk_en) begin
      if (take) begin
        rem_r     <= '0;
        quo_r     <= ci.dataa;
        divisor_r <= ci.datab;
      end else if (state_r == cisp_pkg::CISP_DEV_DIV) begin
        rem_r <= rem_ge ? (rem_shift - {1'b0, divisor_r}) : rem_shift;
        quo_r <= quo_step(quo_r, rem_ge);
      end
    end
  end

  // multi-cycle result register; operands held by the processor meanwhile
  // the final step is loaded here so result and done rise together
  always_ff @(posedge ci.clk) begin
    if (ci.reset) begin
      result_r <= cisp_pkg::RESULT_RST;
    end else if (ci.clk_en) begin
      if (take && !is_iter(op_full)) begin
        result_r <= comb_out;
      end else if (finish && state_r == cisp_pkg::CISP_DEV_MUL) begin
        result_r <= mul_step(acc_r, mcand_r, mplier_r[0]);
      end else if (finish && state_r == cisp_pkg::CISP_DEV_DIV) begin
        result_r <= quo_step(quo_r, rem_ge);
      end
    end
  end
  assign ci.result = result_r;

  // done: one qualified cycle, aligned with the result it marks
  always_ff @(posedge ci.clk) begin
    if (ci.reset) begin
      done_r <= 1'b0;
    end else if (ci.clk_en) begin
      done_r <= VAR_LEN && ((take && !is_iter(op_full)) || finish);
    end
  end
  assign ci.done = done_r;

  // external interface signals of the multi-cycle part
  always_ff @(posedge ci.clk) begin
    if (ci.reset) begin
      op_pulse_r <= 1'b0;
      op_count_r <= '0;
    end else begin
      op_pulse_r <= take;
      if (take) begin
        op_count_r <= op_count_r + 16'h0001;
      end
    end
  end

  // busy flag for external logic, registered in step with the sequencer
  always_ff @(posedge ci.clk) begin
    if (ci.reset) begin
      busy_r <= 1'b0;
    end else if (ci.clk_en) begin
      if (take && is_iter(op_full)) begin
        busy_r <= 1'b1;
      end else if (finish) begin
        busy_r <= 1'b0;
      end
    end
  end

  assign o_ext_busy     = busy_r;
  assign o_ext_op_pulse = op_pulse_r;
  assign o_ext_op_count = op_count_r;
endmodule // cisp_dev
`default_nettype wire

// *** core/cisp_cpu.sv ***
// processor issue/writeback end of the custom instruction slot port
// assumes i_core_clk is the same clock that feeds the interface
`timescale 1ns/1ps
`default_nettype none
module cisp_cpu #(
  parameter bit VAR_LEN      = cisp_pkg::VAR_LEN_DEF,
  parameter int FIXED_CYCLES = cisp_pkg::FIXED_CYCLES_DEF
) (
  input  wire logic                            i_core_clk,
  input  wire logic                            i_rstn,
  input  wire logic                            i_clk_qual,
  input  wire logic                            i_req_valid,
  input  wire logic                            i_req_multi,
  input  wire logic [cisp_pkg::SEL_MAX_W-1:0]  i_req_op,
  input  wire logic [cisp_pkg::DATA_W-1:0]     i_req_a,
  input  wire logic [cisp_pkg::DATA_W-1:0]     i_req_b,
  output logic                                 o_req_ready,
  output logic                                 o_rsp_valid,
  output logic      [cisp_pkg::DATA_W-1:0]     o_rsp_data,
  cisp_if.cpu                                  ci
);
  localparam int CW = $clog2(FIXED_CYCLES + 1);
  localparam logic [CW-1:0] LAST_CNT = CW'(FIXED_CYCLES - 1);

  cisp_pkg::cisp_cpu_st_t state_r;
  logic [cisp_pkg::DATA_W-1:0]    opa_r;
  logic [cisp_pkg::DATA_W-1:0]    opb_r;
  logic [cisp_pkg::SEL_MAX_W-1:0] op_r;
  logic                           start_r;
  logic [CW-1:0]                  cnt_r;
  logic                           mc_end;
  logic                           rsp_valid_r;
  logic [cisp_pkg::DATA_W-1:0]    rsp_data_r;

  assign ci.reset  = ~i_rstn;
  assign ci.clk_en = i_clk_qual;
  assign ci.dataa  = opa_r;
  assign ci.datab  = opb_r;
  assign ci.n      = op_r;
  assign ci.start  = start_r;
  assign o_req_ready = (state_r == cisp_pkg::CISP_CPU_IDLE);
  assign o_rsp_valid = rsp_valid_r;
  assign o_rsp_data  = rsp_data_r;

  // end of a multi-cycle operation on a qualified edge after start was taken
  assign mc_end = (state_r == cisp_pkg::CISP_CPU_MULTI) && i_clk_qual && !start_r &&
                  (VAR_LEN ? ci.done : (cnt_r == LAST_CNT));

  // operands and select held from issue to the end of execution
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      opa_r <= '0;
      opb_r <= '0;
      op_r  <= '0;
    end else if (o_req_ready && i_req_valid) begin
      opa_r <= i_req_a;
      opb_r <= i_req_b;
      op_r  <= i_req_op;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      state_r <= cisp_pkg::CISP_CPU_IDLE;
      start_r <= 1'b0;
      cnt_r   <= '0;
    end else begin
      unique case (state_r)
        cisp_pkg::CISP_CPU_IDLE: begin
          cnt_r <= '0;
          if (i_req_valid) begin
            state_r <= i_req_multi ? cisp_pkg::CISP_CPU_MULTI : cisp_pkg::CISP_CPU_COMB;
            start_r <= i_req_multi;
          end
        end
        cisp_pkg::CISP_CPU_COMB: begin
          state_r <= cisp_pkg::CISP_CPU_IDLE;
        end
        cisp_pkg::CISP_CPU_MULTI: begin
          if (i_clk_qual) begin
            start_r <= 1'b0;
            cnt_r   <= cnt_r + CW'(1);
          end
          if (mc_end) begin
            state_r <= cisp_pkg::CISP_CPU_IDLE;
          end
        end
      endcase
    end
  end

  // writeback of the sampled result
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      rsp_valid_r <= 1'b0;
      rsp_data_r  <= '0;
    end else begin
      rsp_valid_r <= (state_r == cisp_pkg::CISP_CPU_COMB) || mc_end;
      if (state_r == cisp_pkg::CISP_CPU_COMB) begin
        rsp_data_r <= ci.comb_result;
      end else if (mc_end) begin
        rsp_data_r <= ci.result;
      end
    end
  end
endmodule // cisp_cpu
`default_nettype wire

// *** test/cisp_chk_assertions.sv ***
// concurrent checks on the signals between processor end and custom logic end
// assumes the bench wires the interface signals in as plain inputs
`timescale 1ns/1ps
`default_nettype none
module cisp_chk (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        clk_en,
  input wire logic        start,
  input wire logic        done,
  input wire logic [31:0] dataa,
  input wire logic [31:0] datab,
  input wire logic [7:0]  n,
  input wire logic [31:0] result,
  input wire logic [31:0] comb_result
);
  logic        go;
  logic [31:0] rev_bit;
  logic [31:0] rev_byte;
  assign go       = start && clk_en;
  assign rev_bit  = {<<{dataa}};
  assign rev_byte = {<<8{dataa}};
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_comb_bit_rev: assert property (n == 8'h00 |-> comb_result == rev_bit)
    else $error("bit reverse result wrong");
  a_comb_byte_rev: assert property (n == 8'h01 |-> comb_result == rev_byte)
    else $error("byte reverse result wrong");
  a_comb_add_now: assert property (n == 8'h03 |-> comb_result == dataa + datab)
    else $error("combinational sum wrong");
  a_add_done_next: assert property (go && n == 8'h03 |=>
    done && result == $past(dataa) + $past(datab))
    else $error("add not completed with done");
  a_mul_not_early: assert property (go && n == 8'h05 |=> !done [*8])
    else $error("multiply finished too early");
  a_done_bounded: assert property (go |=> ##[0:200] done)
    else $error("done never came");
  a_operands_held: assert property (go |=>
    ($stable(n) && $stable(dataa) && $stable(datab)) until done)
    else $error("operands moved during operation");
  a_done_one_cycle: assert property (done && clk_en |=> !done)
    else $error("done longer than one cycle");
  a_qual_holds_state: assert property (!clk_en |=> $stable(result) && $stable(done))
    else $error("state moved on unqualified edge");
  a_reset_values: assert property ($fell(reset) |->
    !done && result == cisp_pkg::RESULT_RST)
    else $error("reset values wrong");

  c_mul_start: cover property (go && n == 8'h05);
  c_qual_low: cover property (!clk_en && !done);
  c_done_seen: cover property ($rose(done));
endmodule // cisp_chk
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench: processor end and custom logic end joined by the interface
// assumes a variable-length pair, a fixed-length pair and a 40 MHz system clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module testbench;
  logic        core_clk;
  logic        rstn;
  logic        qual;
  logic        valid;
  logic        multi;
  logic [7:0]  op;
  logic [31:0] a;
  logic [31:0] b;
  logic        ready;
  logic        rsp_valid;
  logic [31:0] rsp_data;
  logic        ext_busy;
  logic        ext_pulse;
  logic [15:0] ext_count;
  logic        valid_f;
  logic        ready_f;
  logic        rsp_valid_f;
  logic [31:0] rsp_data_f;
  int          err_count;
  int          cmp_count;
  int          cyc;

  cisp_if ci (.clk(core_clk));
  cisp_cpu #(.VAR_LEN(1'b1), .FIXED_CYCLES(cisp_pkg::FIXED_CYCLES_DEF)) i_cisp_cpu (
    .i_core_clk(core_clk), .i_rstn(rstn), .i_clk_qual(qual), .i_req_valid(valid),
    .i_req_multi(multi), .i_req_op(op), .i_req_a(a), .i_req_b(b), .o_req_ready(ready),
    .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data), .ci(ci));
  cisp_dev #(.VAR_LEN(1'b1), .NUM_OPS(cisp_pkg::NUM_OPS_DEF)) i_cisp_dev (
    .ci(ci), .o_ext_busy(ext_busy), .o_ext_op_pulse(ext_pulse), .o_ext_op_count(ext_count));
  cisp_chk i_cisp_chk (.clk(ci.clk), .reset(ci.reset), .clk_en(ci.clk_en), .start(ci.start),
    .done(ci.done), .dataa(ci.dataa), .datab(ci.datab), .n(ci.n), .result(ci.result),
    .comb_result(ci.comb_result));
  cisp_if ci_f (.clk(core_clk));
  cisp_cpu #(.VAR_LEN(1'b0), .FIXED_CYCLES(cisp_pkg::FIXED_CYCLES_DEF)) i_cisp_cpu_fix (
    .i_core_clk(core_clk), .i_rstn(rstn), .i_clk_qual(qual), .i_req_valid(valid_f),
    .i_req_multi(multi), .i_req_op(op), .i_req_a(a), .i_req_b(b), .o_req_ready(ready_f),
    .o_rsp_valid(rsp_valid_f), .o_rsp_data(rsp_data_f), .ci(ci_f));
  cisp_dev #(.VAR_LEN(1'b0), .NUM_OPS(cisp_pkg::NUM_OPS_DEF)) i_cisp_dev_fix (
    .ci(ci_f), .o_ext_busy(), .o_ext_op_pulse(), .o_ext_op_count());

  always #12.5 core_clk = ~core_clk;

  function automatic logic [31:0] ref_of(input logic [7:0] o, input logic [31:0] x, y);
    case (o)
      8'h00: ref_of = {<<{x}};
      8'h01: ref_of = {<<8{x}};
      8'h02: ref_of = {x[15:0], x[31:16]};
      8'h03: ref_of = x + y;
      8'h04: ref_of = x - y;
      8'h05: ref_of = x * y;
      8'h06: ref_of = (y == 32'h0) ? 32'hffff_ffff : x / y;
      default: ref_of = 32'h0;
    endcase
  endfunction

  task automatic finish_test();
    $display("errors %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one request, qualifier dropped for gap cycles from the third cycle after take
  task automatic run_op(input logic m, input logic [7:0] o, input logic [31:0] x, y,
                        input int lat, input int gap);
    int k;
    @(negedge core_clk);
    valid = 1'b1;
    multi = m;
    op = o;
    a = x;
    b = y;
    while (ready !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    valid = 1'b0;
    k = 1;
    while (rsp_valid !== 1'b1 && k < 400) begin
      qual = !(k >= 4 && k < 4 + gap);
      @(negedge core_clk);
      k++;
      if (k == 2) begin
        `CHK("ext_pulse", m, ext_pulse)
        `CHK("ext_busy", m && (o == 8'h05 || o == 8'h06), ext_busy)
      end
    end
    qual = 1'b1;
    `CHK("rsp_data", ref_of(o, x, y), rsp_data)
    `CHK("latency", lat, k)
  endtask

  task automatic t_reset();
    `CHK("ready", 1'b1, ready)
    `CHK("rsp_valid", 1'b0, rsp_valid)
    `CHK("rsp_data", 32'h0, rsp_data)
    `CHK("ext", 18'h0, {ext_busy, ext_pulse, ext_count})
  endtask

  task automatic t_comb();
    for (int i = 0; i < 5; i++)
      run_op(1'b0, 8'(i), 32'h1234_5678, 32'h0f0f_1111, 2, 0);
    run_op(1'b0, 8'h07, 32'h1234_5678, 32'h0f0f_1111, 2, 0);
  endtask

  task automatic t_multi();
    for (int i = 0; i < 7; i++)
      run_op(1'b1, 8'(i), 32'h8765_4321, 32'h0000_0013, i < 5 ? 3 : 35, 0);
    run_op(1'b1, 8'h06, 32'h0000_00aa, 32'h0, 35, 0);
  endtask

  task automatic t_stall();
    run_op(1'b1, 8'h05, 32'hdead_0007, 32'h0001_0003, 38, 3);
    `CHK("ext_count", 16'h0009, ext_count)
  endtask

  // one multi-cycle request on the fixed-length pair, qualifier held high
  task automatic run_fix(input logic [7:0] o, input logic [31:0] x, y);
    int k;
    @(negedge core_clk);
    valid_f = 1'b1;
    multi = 1'b1;
    op = o;
    a = x;
    b = y;
    @(negedge core_clk);
    valid_f = 1'b0;
    k = 1;
    while (rsp_valid_f !== 1'b1 && k < 400) begin
      @(negedge core_clk);
      k++;
    end
    `CHK("fix_data", ref_of(o, x, y), rsp_data_f)
    `CHK("fix_latency", cisp_pkg::FIXED_CYCLES_DEF + 1, k)
    `CHK("fix_done", 1'b0, ci_f.done)
    `CHK("fix_ready", 1'b1, ready_f)
  endtask

  task automatic t_fixed();
    run_fix(8'h03, 32'h1234_5678, 32'h0f0f_1111);
    run_fix(8'h05, 32'hdead_0007, 32'h0001_0003);
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      finish_test();
    end
  end

  initial begin
    core_clk = 1'b0;
    rstn = 1'b0;
    qual = 1'b1;
    valid = 1'b0;
    valid_f = 1'b0;
    multi = 1'b0;
    op = 8'h00;
    a = 32'h0;
    b = 32'h0;
    repeat (6) @(negedge core_clk);
    t_reset();
    rstn = 1'b1;
    t_comb();
    t_multi();
    t_stall();
    t_fixed();
    finish_test();
  end
endmodule // testbench
`default_nettype wire
